// [gauge_pkg.sv]
// shared constants for the fuel gauge tuning bank
package gauge_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0]  IDX_TUNING_THREE  = 10'h0eb;
   localparam logic [9:0]  IDX_TUNING_FOUR   = 10'h0ec;
   localparam logic [9:0]  IDX_TUNING_FIVE   = 10'h0ed;
   localparam logic [11:0] ADDR_TUNING_THREE = {IDX_TUNING_THREE, 2'b00};
   localparam logic [11:0] ADDR_TUNING_FOUR  = {IDX_TUNING_FOUR, 2'b00};
   localparam logic [11:0] ADDR_TUNING_FIVE  = {IDX_TUNING_FIVE, 2'b00};
   localparam logic [7:0]  RESET_TUNING_THREE = 8'h00;
   localparam logic [7:0]  RESET_TUNING_FOUR  = 8'h00;
   localparam logic [7:0]  RESET_TUNING_FIVE  = 8'h00;
   // field positions
   localparam int CUR_COND_BIT   = 3;
   localparam int PCT_THR_LSB    = 0;
   localparam int INCL_OFS_BIT   = 7;
   localparam int SMOOTH_OFS_BIT = 6;
   localparam int PWRON_CALC_BIT = 5;
   localparam int VMIN_LSB       = 3;
   localparam int CAL_OFS_LSB    = 0;
   localparam int RATE_EN_BIT    = 7;
   localparam int FAST_SEL_BIT   = 6;
   localparam int MID_SEL_LSB    = 4;
   localparam int SLOW_SEL_LSB   = 2;
   localparam int FIXED_SEL_LSB  = 0;
   // thresholds
   localparam logic [11:0] CUR_MIN_HIGH_MA = 12'h12c;
   localparam logic [11:0] CUR_MIN_LOW_MA  = 12'h096;
   localparam logic [12:0] VMIN_3400_MV    = 13'hd48;
   localparam logic [12:0] VMIN_3500_MV    = 13'hdac;
   localparam logic [12:0] VMIN_3600_MV    = 13'he10;
   localparam logic [12:0] VMIN_3700_MV    = 13'he74;
   localparam logic [2:0]  PCT_THR_FLIP    = 3'h4;
   localparam logic [4:0]  CAL_ADD_HIGH    = 5'h07;
   localparam logic [4:0]  CAL_ADD_LOW     = 5'h03;
   // update intervals in seconds
   localparam logic [7:0] UPD_15_S  = 8'h0f;
   localparam logic [7:0] UPD_30_S  = 8'h1e;
   localparam logic [7:0] UPD_45_S  = 8'h2d;
   localparam logic [7:0] UPD_60_S  = 8'h3c;
   localparam logic [7:0] UPD_75_S  = 8'h4b;
   localparam logic [7:0] UPD_120_S = 8'h78;
   localparam logic [7:0] UPD_180_S = 8'hb4;
   localparam logic [7:0] UPD_240_S = 8'hf0;
   // rate classes
   localparam logic [1:0] RATE_SLOW = 2'h0;
   localparam logic [1:0] RATE_MID  = 2'h1;
   localparam logic [1:0] RATE_FAST = 2'h2;
   // timing
   localparam int unsigned CLK_PERIOD_NS     = 10;
   localparam int unsigned ONE_SECOND_NS     = 1000000000;
   localparam int unsigned CYCLES_PER_SECOND = ONE_SECOND_NS / CLK_PERIOD_NS;
endpackage : gauge_pkg

// [gauge_link_if.sv]
// signals between the tuning bank and its helper modules
`timescale 1ns/1ns
interface gauge_link_if;
   logic        sec_tick;
   logic [11:0] raw_current;
   logic [11:0] offset_term;
   logic        sample_valid;
   logic        include_offset;
   logic        smooth_offset;
   logic [11:0] reported_current;
   logic        reported_valid;
   modport divider (output sec_tick);
   modport offset_path (input raw_current, offset_term, sample_valid, include_offset, smooth_offset,
                        output reported_current, reported_valid);
   modport core (input sec_tick, reported_current, reported_valid,
                 output raw_current, offset_term, sample_valid, include_offset, smooth_offset);
endinterface : gauge_link_if

// [second_divider.sv]
// one-second enable pulse from the bus clock
`timescale 1ns/1ns
module second_divider
#(
   parameter int unsigned cycles_per_second = gauge_pkg::CYCLES_PER_SECOND
)
(
   input  wire logic  pclk,
   input  wire logic  presetn,
   gauge_link_if.divider link
);
   typedef struct packed {
      logic [26:0] count;
      logic        tick;
   } div_state_t;

   div_state_t state;
   div_state_t next_state;

   always_comb
   begin
      next_state = state;
      next_state.tick = 1'b0;
      if (state.count == 27'(cycles_per_second - 1))
      begin
         next_state.count = 27'h0000000;
         next_state.tick = 1'b1;
      end
      else
      begin
         next_state.count = state.count + 27'h0000001;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= '0;
      else
         state <= next_state;
   end

   assign link.sec_tick = state.tick;
endmodule : second_divider

// [current_offset_path.sv]
// current sample offset removal with optional smoothing
`timescale 1ns/1ns
module current_offset_path
(
   input  wire logic      pclk,
   input  wire logic      presetn,
   gauge_link_if.offset_path link
);
   typedef struct packed {
      logic [11:0] smoothed;
      logic [11:0] reported;
      logic        valid;
   } ofs_state_t;

   ofs_state_t  state;
   ofs_state_t  next_state;
   logic [14:0] acc;
   logic [11:0] new_offset;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   always_comb
   begin
      next_state = state;
      next_state.valid = 1'b0;
      // seven eighths old plus one eighth new; first samples ramp up from zero
      acc = ({state.smoothed, 3'b000} - {3'b000, state.smoothed}) + {3'b000, link.offset_term};
      new_offset = link.smooth_offset ? acc[14:3] : link.offset_term;
      if (link.sample_valid)
      begin
         next_state.smoothed = new_offset;
         next_state.reported = link.raw_current - (link.include_offset ? new_offset : 12'h000);
         next_state.valid = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= '0;
      else
         state <= next_state;
   end

   assign link.reported_current = state.reported;
   assign link.reported_valid = state.valid;

   property p_offset_excluded;
      link.sample_valid && !link.include_offset |=> link.reported_current == $past(link.raw_current);
   endproperty
   a_offset_excluded : assert property (p_offset_excluded) else $error("offset not excluded");

   property p_smooth_off;
      link.sample_valid && !link.smooth_offset && link.include_offset
         |=> link.reported_current == $past(link.raw_current) - $past(link.offset_term);
   endproperty
   a_smooth_off : assert property (p_smooth_off) else $error("unsmoothed offset wrong");
endmodule : current_offset_path

// [fuel_gauge_tuning_config.sv]
// fuel gauge tuning register bank with apb slave and the decisions it steers
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module fuel_gauge_tuning_config
#(
   parameter int unsigned cycles_per_second = gauge_pkg::CYCLES_PER_SECOND
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [11:0] battery_current_ma,
   input  wire logic [12:0] battery_voltage_mv,
   input  wire logic        resistance_calc_request,
   input  wire logic [6:0]  rest_pct_change,
   input  wire logic        power_on_from_off,
   input  wire logic [3:0]  base_threshold,
   input  wire logic [1:0]  rate_class,
   input  wire logic [11:0] raw_current,
   input  wire logic [11:0] first_current_offset,
   input  wire logic        sample_valid,
   output logic             resistance_calc_start,
   output logic             resistance_recalibrate,
   output logic             resistance_power_on_calc,
   output logic      [4:0]  counter_cal_threshold,
   output logic      [7:0]  update_interval_s,
   output logic             percent_update,
   output logic      [11:0] reported_current,
   output logic             reported_valid
);
   typedef struct packed {
      logic [7:0]  tuning_three;
      logic [7:0]  tuning_four;
      logic [7:0]  tuning_five;
      logic [31:0] prdata;
      logic        calc_start;
      logic        recal;
      logic        power_on_calc;
      logic [4:0]  cal_threshold;
      logic [7:0]  interval;
      logic [7:0]  sec_count;
      logic        percent_update;
   } core_state_t;

   core_state_t state;
   core_state_t next_state;
   logic        hit_three;
   logic        hit_four;
   logic        hit_five;
   logic        mapped;
   logic        current_ok;
   logic        voltage_ok;
   logic [2:0]  pct_threshold;

   gauge_link_if link ();

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   function automatic logic [12:0] min_voltage(input logic [1:0] code);
      logic [12:0] v;
      v = gauge_pkg::VMIN_3500_MV;
      unique case (code)
         2'b00: v = gauge_pkg::VMIN_3500_MV;
         2'b01: v = gauge_pkg::VMIN_3600_MV;
         2'b10: v = gauge_pkg::VMIN_3700_MV;
         2'b11: v = gauge_pkg::VMIN_3400_MV;
      endcase
      return v;
   endfunction : min_voltage

   function automatic logic [7:0] pick_interval(input logic [7:0] five, input logic [1:0] rate);
      logic [7:0] t;
      t = gauge_pkg::UPD_30_S;
      if (!five[gauge_pkg::RATE_EN_BIT])
      begin
         unique case (five[gauge_pkg::FIXED_SEL_LSB +: 2])
            2'b00: t = gauge_pkg::UPD_30_S;
            2'b01: t = gauge_pkg::UPD_45_S;
            2'b10: t = gauge_pkg::UPD_60_S;
            2'b11: t = gauge_pkg::UPD_15_S;
         endcase
      end
      else if (rate == gauge_pkg::RATE_FAST)
      begin
         t = five[gauge_pkg::FAST_SEL_BIT] ? gauge_pkg::UPD_15_S : gauge_pkg::UPD_30_S;
      end
      else if (rate == gauge_pkg::RATE_MID)
      begin
         unique case (five[gauge_pkg::MID_SEL_LSB +: 2])
            2'b00: t = gauge_pkg::UPD_60_S;
            2'b01: t = gauge_pkg::UPD_75_S;
            2'b10: t = gauge_pkg::UPD_30_S;
            2'b11: t = gauge_pkg::UPD_45_S;
         endcase
      end
      else
      begin
         unique case (five[gauge_pkg::SLOW_SEL_LSB +: 2])
            2'b00: t = gauge_pkg::UPD_120_S;
            2'b01: t = gauge_pkg::UPD_180_S;
            2'b10: t = gauge_pkg::UPD_240_S;
            2'b11: t = gauge_pkg::UPD_60_S;
         endcase
      end
      return t;
   endfunction : pick_interval

   assign hit_three = paddr == gauge_pkg::ADDR_TUNING_THREE;
   assign hit_four = paddr == gauge_pkg::ADDR_TUNING_FOUR;
   assign hit_five = paddr == gauge_pkg::ADDR_TUNING_FIVE;
   assign mapped = hit_three | hit_four | hit_five;

   // rate class 3 is not defined and falls to the slow table
   assign current_ok = battery_current_ma >= (state.tuning_three[gauge_pkg::CUR_COND_BIT] ?
                       gauge_pkg::CUR_MIN_LOW_MA : gauge_pkg::CUR_MIN_HIGH_MA);
   assign voltage_ok = battery_voltage_mv >= min_voltage(state.tuning_four[gauge_pkg::VMIN_LSB +: 2]);
   // codes 000..011 map to 4..7 and 100..111 to 0..3, so flipping the top bit decodes it
   assign pct_threshold = state.tuning_three[gauge_pkg::PCT_THR_LSB +: 3] ^ gauge_pkg::PCT_THR_FLIP;

   always_comb
   begin
      next_state = state;
      next_state.percent_update = 1'b0;
      next_state.power_on_calc = 1'b0;
      // read data captured in setup so the access phase answers from a flop
      if (psel && !penable)
      begin
         next_state.prdata = 32'h00000000;
         if (hit_three)
            next_state.prdata[7:0] = state.tuning_three;
         if (hit_four)
            next_state.prdata[7:0] = state.tuning_four;
         if (hit_five)
            next_state.prdata[7:0] = state.tuning_five;
      end
      if (psel && penable && pwrite && pstrb[0])
      begin
         if (hit_three)
            next_state.tuning_three = pwdata[7:0];
         if (hit_four)
            next_state.tuning_four = pwdata[7:0];
         if (hit_five)
            next_state.tuning_five = pwdata[7:0];
      end
      next_state.calc_start = resistance_calc_request && current_ok && voltage_ok;
      next_state.recal = rest_pct_change > {4'h0, pct_threshold};
      next_state.power_on_calc = power_on_from_off && state.tuning_four[gauge_pkg::PWRON_CALC_BIT];
      next_state.cal_threshold = {1'b0, base_threshold}
         + (state.tuning_four[gauge_pkg::CAL_OFS_LSB + 2] ? gauge_pkg::CAL_ADD_LOW : gauge_pkg::CAL_ADD_HIGH)
         + {3'b000, state.tuning_four[gauge_pkg::CAL_OFS_LSB +: 2]};
      next_state.interval = pick_interval(state.tuning_five, rate_class);
      // an interval shortened below the running count fires on the next second
      if (link.sec_tick)
      begin
         if ({1'b0, state.sec_count} + 9'h001 >= {1'b0, state.interval})
         begin
            next_state.sec_count = 8'h00;
            next_state.percent_update = 1'b1;
         end
         else
         begin
            next_state.sec_count = state.sec_count + 8'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= '0;
         state.tuning_three <= gauge_pkg::RESET_TUNING_THREE;
         state.tuning_four <= gauge_pkg::RESET_TUNING_FOUR;
         state.tuning_five <= gauge_pkg::RESET_TUNING_FIVE;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign prdata = state.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign resistance_calc_start = state.calc_start;
   assign resistance_recalibrate = state.recal;
   assign resistance_power_on_calc = state.power_on_calc;
   assign counter_cal_threshold = state.cal_threshold;
   assign update_interval_s = state.interval;
   assign percent_update = state.percent_update;
   assign reported_current = link.reported_current;
   assign reported_valid = link.reported_valid;

   assign link.raw_current = raw_current;
   assign link.offset_term = first_current_offset;
   assign link.sample_valid = sample_valid;
   assign link.include_offset = !state.tuning_four[gauge_pkg::INCL_OFS_BIT];
   assign link.smooth_offset = !state.tuning_four[gauge_pkg::SMOOTH_OFS_BIT];

   second_divider #(.cycles_per_second(cycles_per_second)) u_divider
   (
      .pclk    (pclk),
      .presetn (presetn),
      .link    (link.divider)
   );

   current_offset_path u_offset
   (
      .pclk    (pclk),
      .presetn (presetn),
      .link    (link.offset_path)
   );

   property p_current_low;
      resistance_calc_request && battery_current_ma < 12'h096 |=> !resistance_calc_start;
   endproperty
   a_current_low : assert property (p_current_low) else $error("calc started below 150 mA");

   property p_current_high;
      resistance_calc_request && !state.tuning_three[3] && battery_current_ma < 12'h12c
         |=> !resistance_calc_start;
   endproperty
   a_current_high : assert property (p_current_high) else $error("calc started below 300 mA");

   property p_recal_zero;
      state.tuning_three[2:0] == 3'h4 && rest_pct_change == 7'h01 |=> resistance_recalibrate;
   endproperty
   a_recal_zero : assert property (p_recal_zero) else $error("recal missed at 0 percent");

   property p_recal_four;
      state.tuning_three[2:0] == 3'h0 && rest_pct_change == 7'h04 |=> !resistance_recalibrate;
   endproperty
   a_recal_four : assert property (p_recal_four) else $error("recal at 4 percent change");

   property p_power_on;
      power_on_from_off |=> resistance_power_on_calc == $past(state.tuning_four[5]);
   endproperty
   a_power_on : assert property (p_power_on) else $error("power-on recompute wrong");

   property p_voltage_min;
      resistance_calc_request && battery_voltage_mv < 13'hd48 |=> !resistance_calc_start;
   endproperty
   a_voltage_min : assert property (p_voltage_min) else $error("calc started below 3.4 V");

   property p_cal_default;
      state.tuning_four[2:0] == 3'h0 |=> counter_cal_threshold == {1'b0, $past(base_threshold)} + 5'h07;
   endproperty
   a_cal_default : assert property (p_cal_default) else $error("cal threshold not base plus 7");

   property p_rate_off;
      !state.tuning_five[7] && state.tuning_five[1:0] == 2'b00 |=> update_interval_s == 8'h1e;
   endproperty
   a_rate_off : assert property (p_rate_off) else $error("rate used while disabled");

   property p_fast;
      state.tuning_five[7] && rate_class == 2'h2 && state.tuning_five[6] |=> update_interval_s == 8'h0f;
   endproperty
   a_fast : assert property (p_fast) else $error("fast interval not 15 s");

   property p_mid;
      state.tuning_five[7] && rate_class == 2'h1 && state.tuning_five[5:4] == 2'b01
         |=> update_interval_s == 8'h4b;
   endproperty
   a_mid : assert property (p_mid) else $error("mid interval not 75 s");

   property p_slow;
      state.tuning_five[7] && rate_class == 2'h0 && state.tuning_five[3:2] == 2'b10
         |=> update_interval_s == 8'hf0;
   endproperty
   a_slow : assert property (p_slow) else $error("slow interval not 240 s");

   property p_fixed;
      !state.tuning_five[7] && state.tuning_five[1:0] == 2'b11 |=> update_interval_s == 8'h0f;
   endproperty
   a_fixed : assert property (p_fixed) else $error("fixed interval not 15 s");
endmodule : fuel_gauge_tuning_config

// [fuel_gauge_tuning_config_tb.sv]
// self-checking bench for the fuel gauge tuning bank
`timescale 1ns/1ns
`define CHK(got, exp, msg) check(32'(got), 32'(exp), msg)
module fuel_gauge_tuning_config_tb;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [11:0] battery_current_ma;
   logic [12:0] battery_voltage_mv;
   logic        resistance_calc_request;
   logic [6:0]  rest_pct_change;
   logic        power_on_from_off;
   logic [3:0]  base_threshold;
   logic [1:0]  rate_class;
   logic [11:0] raw_current;
   logic [11:0] first_current_offset;
   logic        sample_valid;
   logic        resistance_calc_start;
   logic        resistance_recalibrate;
   logic        resistance_power_on_calc;
   logic [4:0]  counter_cal_threshold;
   logic [7:0]  update_interval_s;
   logic        percent_update;
   logic [11:0] reported_current;
   logic        reported_valid;
   int          bad_count;
   int          cmp_count;
   logic [31:0] rd;
   logic        er;
   int          n;
   logic [7:0]  fixed_tab [4] = '{8'h1e, 8'h2d, 8'h3c, 8'h0f};
   logic [7:0]  mid_tab   [4] = '{8'h3c, 8'h4b, 8'h1e, 8'h2d};
   logic [7:0]  slow_tab  [4] = '{8'h78, 8'hb4, 8'hf0, 8'h3c};
   logic [12:0] vmin_tab  [4] = '{13'hdac, 13'he10, 13'he74, 13'hd48};

   // short divider keeps a 15 s interval at 150 cycles
   fuel_gauge_tuning_config #(.cycles_per_second(10)) u_fuel_gauge_tuning_config
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .battery_current_ma(battery_current_ma),
      .battery_voltage_mv(battery_voltage_mv), .resistance_calc_request(resistance_calc_request),
      .rest_pct_change(rest_pct_change), .power_on_from_off(power_on_from_off),
      .base_threshold(base_threshold), .rate_class(rate_class), .raw_current(raw_current),
      .first_current_offset(first_current_offset), .sample_valid(sample_valid),
      .resistance_calc_start(resistance_calc_start), .resistance_recalibrate(resistance_recalibrate),
      .resistance_power_on_calc(resistance_power_on_calc), .counter_cal_threshold(counter_cal_threshold),
      .update_interval_s(update_interval_s), .percent_update(percent_update),
      .reported_current(reported_current), .reported_valid(reported_valid)
   );

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out

   task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : check

   // one apb transfer; request held until pready is seen at an edge
   task apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         check(32'h0, 32'h1, "apb wait limit");
         close_out;
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 4'h1);
   endtask : wr

   // decisions are two edges behind a write, one behind an input
   task settle;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
   endtask : settle

   task sample(input logic [11:0] r, input logic [11:0] o, input logic [11:0] exp);
      @(posedge pclk);
      raw_current          <= r;
      first_current_offset <= o;
      sample_valid         <= 1'b1;
      @(posedge pclk);
      sample_valid <= 1'b0;
      @(negedge pclk);
      `CHK(reported_valid, 1'b1, "reported valid");
      `CHK(reported_current, exp, "reported current");
   endtask : sample

   task level(input logic exp_po);
      @(posedge pclk);
      power_on_from_off <= 1'b1;
      @(posedge pclk);
      power_on_from_off <= 1'b0;
      @(negedge pclk);
      `CHK(resistance_power_on_calc, exp_po, "power on calc pulse");
      @(negedge pclk);
      `CHK(resistance_power_on_calc, 1'b0, "power on calc pulse width");
   endtask : level

   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {battery_current_ma, battery_voltage_mv, resistance_calc_request, rest_pct_change} = '0;
      {power_on_from_off, base_threshold, rate_class, raw_current, first_current_offset} = '0;
      sample_valid = 1'b0;
      bad_count = 0;
      cmp_count = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b0, gauge_pkg::ADDR_TUNING_THREE + 12'(4 * i), 8'h00, 4'h0);
         `CHK(rd, 32'h0, "reset value");
      end
      // the smoother starts from zero, so run it before any other sample
      sample(12'h3e8, 12'h320, 12'h384);
      sample(12'h3e8, 12'h320, 12'h32d);
      wr(gauge_pkg::ADDR_TUNING_FOUR, 8'h40);
      sample(12'h3e8, 12'h064, 12'h384);
      wr(gauge_pkg::ADDR_TUNING_FOUR, 8'hc0);
      sample(12'h3e8, 12'h064, 12'h3e8);
      $display("test offset path done");
      for (int i = 0; i < 3; i++)
      begin
         wr(gauge_pkg::ADDR_TUNING_THREE + 12'(4 * i), 8'h5a);
         apb(1'b1, gauge_pkg::ADDR_TUNING_THREE + 12'(4 * i), 8'hff, 4'h0);
         apb(1'b0, gauge_pkg::ADDR_TUNING_THREE + 12'(4 * i), 8'h00, 4'h0);
         `CHK(rd, 32'h5a, "readback");
         `CHK(er, 1'b0, "mapped access error");
         wr(gauge_pkg::ADDR_TUNING_THREE + 12'(4 * i), 8'h00);
      end
      apb(1'b0, 12'h3b8, 8'h00, 4'h0);
      `CHK({rd, er}, {32'h0, 1'b1}, "unmapped read");
      $display("test registers done");
      @(posedge pclk);
      resistance_calc_request <= 1'b1;
      battery_voltage_mv      <= 13'hdac;
      battery_current_ma      <= 12'h12b;
      settle;
      `CHK(resistance_calc_start, 1'b0, "299 ma refused");
      @(posedge pclk);
      battery_current_ma <= 12'h12c;
      settle;
      `CHK(resistance_calc_start, 1'b1, "300 ma accepted");
      wr(gauge_pkg::ADDR_TUNING_THREE, 8'h08);
      battery_current_ma <= 12'h095;
      settle;
      `CHK(resistance_calc_start, 1'b0, "149 ma refused");
      @(posedge pclk);
      battery_current_ma <= 12'h096;
      settle;
      `CHK(resistance_calc_start, 1'b1, "150 ma accepted");
      for (int c = 0; c < 4; c++)
      begin
         wr(gauge_pkg::ADDR_TUNING_FOUR, 8'(c << 3));
         battery_current_ma <= 12'h12c;
         battery_voltage_mv <= vmin_tab[c] - 13'h1;
         settle;
         `CHK(resistance_calc_start, 1'b0, "below minimum voltage");
         @(posedge pclk);
         battery_voltage_mv <= vmin_tab[c];
         settle;
         `CHK(resistance_calc_start, 1'b1, "at minimum voltage");
      end
      for (int c = 0; c < 8; c++)
      begin
         n = (c < 4) ? c + 4 : c - 4;
         wr(gauge_pkg::ADDR_TUNING_THREE, 8'(c));
         rest_pct_change <= 7'(n);
         settle;
         `CHK(resistance_recalibrate, 1'b0, "change equal to threshold");
         @(posedge pclk);
         rest_pct_change <= 7'(n + 1);
         settle;
         `CHK(resistance_recalibrate, 1'b1, "change above threshold");
      end
      base_threshold <= 4'hf;
      for (int c = 0; c < 8; c++)
      begin
         wr(gauge_pkg::ADDR_TUNING_FOUR, 8'(c));
         settle;
         `CHK(counter_cal_threshold, (c < 4) ? 22 + c : 14 + c, "calibration threshold");
      end
      $display("test resistance decisions done");
      wr(gauge_pkg::ADDR_TUNING_FOUR, 8'h20);
      level(1'b1);
      wr(gauge_pkg::ADDR_TUNING_FOUR, 8'h00);
      level(1'b0);
      $display("test power on recompute done");
      for (int i = 0; i < 4; i++)
      begin
         wr(gauge_pkg::ADDR_TUNING_FIVE, 8'(i));
         settle;
         `CHK(update_interval_s, fixed_tab[i], "fixed interval");
         wr(gauge_pkg::ADDR_TUNING_FIVE, 8'(8'h80 | ((i & 1) << 6) | (i << 4) | (i << 2)));
         for (int r = 0; r < 4; r++)
         begin
            rate_class <= 2'(r);
            settle;
            if (r == 1)
               `CHK(update_interval_s, mid_tab[i], "mid rate interval");
            else if (r == 2)
               `CHK(update_interval_s, (i & 1) ? 8'h0f : 8'h1e, "fast rate interval");
            else
               `CHK(update_interval_s, slow_tab[i], "slow rate interval");
            @(posedge pclk);
         end
      end
      wr(gauge_pkg::ADDR_TUNING_FIVE, 8'h03);
      for (int p = 0; p < 2; p++)
      begin
         n = 0;
         do
         begin
            // pulse is looked at mid-cycle, away from the edge that launches it
            @(negedge pclk);
            n++;
         end
         while (percent_update !== 1'b1 && n < 4000);
         if (n >= 4000)
         begin
            check(32'h0, 32'h1, "percent update wait limit");
            close_out;
         end
      end
      `CHK(n, 150, "percent update period");
      $display("test update intervals done");
      // reset again mid-run; tuning five register and sample output must return to zero
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, gauge_pkg::ADDR_TUNING_FIVE, 8'h00, 4'h0);
      `CHK(rd, 32'h0, "register after second reset");
      `CHK(reported_current, 12'h000, "sample output after second reset");
      $display("test second reset done");
      close_out;
   end
endmodule : fuel_gauge_tuning_config_tb
